// file: verilog/tx_cell_insert_regs.svh
`ifndef TX_CELL_INSERT_REGS_SVH
`define TX_CELL_INSERT_REGS_SVH
// ==================================================
// register offsets (low byte of the page address)
`define OFS_INT_STATUS   8'h0B
`define OFS_INT_ENABLE   8'h0F
`define OFS_MEM_CONTROL  8'h13
`define OFS_INS_DATA3    8'h14
`define OFS_INS_DATA2    8'h15
`define OFS_INS_DATA1    8'h16
`define OFS_INS_DATA0    8'h17
`define OFS_CNT_BYTE3    2'h0
`define OFS_CNT_FIRST    4'h4
`define OFS_CNT_LAST     4'h7
`define OFS_CNT_SLOT     2'h3
// ==================================================
// field positions and reset values
`define BIT_WRITE_SOC    0
`define BIT_ROOM         1
`define BIT_INS_RESET_N  2
`define BIT_INS_INT      4
`define RST_MEM_CONTROL  8'h14
`define RST_INT_ENABLE   8'h10
// ==================================================
// sizes and counts
`define CELL_WORDS       5'h0E
`define LAST_WORD        5'h0D
`define MEM_ROOM_LIMIT   6'h12
`define CNT_SATURATE     32'h0FFFFFFF
`endif

// file: verilog/tx_cell_insert_pkg.sv
package tx_cell_insert_pkg;
    // one word of a cell on its way to the transmit path
    typedef struct packed {
        logic        startOfCell;
        logic        endOfCell;
        logic [31:0] data;
    } cell_word_t;

    typedef enum logic [0:0] {
        SEND_IDLE = 1'b0,
        SEND_BUSY = 1'b1
    } send_state_t;
endpackage : tx_cell_insert_pkg

// file: verilog/tx_cell_insert.sv
`timescale 1ns/100ps
`include "tx_cell_insert_regs.svh"
module tx_cell_insert
    import tx_cell_insert_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    input  wire logic [3:0] filterHit,
    input  wire logic       txFifoEmpty,
    output cell_word_t      outWord,
    output logic            outValid,
    input  wire logic       outReady,
    output logic            intN
);
    // ==================================================
    // register decode
    logic       selCnt;
    logic [1:0] cntFilter;
    logic [1:0] cntByte;
    assign selCnt    = addr[7:4] >= `OFS_CNT_FIRST && addr[7:4] <= `OFS_CNT_LAST && addr[3:2] == `OFS_CNT_SLOT;
    assign cntFilter = addr[5:4];
    assign cntByte   = addr[1:0];

    // ==================================================
    // filtered cell counters, one per filter
    logic [31:0] cnt_q  [4];
    logic [31:0] snap_q [4];
    for (genvar f = 0; f < 4; f++) begin : g_filter
        logic [31:0] cnt_d;
        logic [31:0] snap_d;
        logic        rdMsb;
        assign rdMsb = rdStb && selCnt && cntFilter == f && cntByte == `OFS_CNT_BYTE3;
        // reading the MSB clears the count; a hit in the same cycle counts as one, so none is lost
        always_comb begin
            cnt_d  = cnt_q[f];
            snap_d = snap_q[f];
            if (rdMsb) begin
                snap_d = cnt_q[f];
                cnt_d  = {31'h0, filterHit[f]};
            end else if (filterHit[f] && cnt_q[f] != `CNT_SATURATE) begin
                cnt_d  = cnt_q[f] + 32'h1;
            end
        end
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                cnt_q[f]  <= 32'h0;
                snap_q[f] <= 32'h0;
            end else begin
                cnt_q[f]  <= cnt_d;
                snap_q[f] <= snap_d;
            end
        end
    end

    // ==================================================
    // insertion memory and word assembly
    logic [31:0] mem [32];
    logic [4:0]  wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, wrIdx_q, wrIdx_d, sendIdx_q, sendIdx_d;
    logic [23:0] asm_q, asm_d;
    logic [7:0]  memCtl_q, memCtl_d, intEn_q, intEn_d, intStat_q, intStat_d, rdData_q, rdData_d;
    logic        flushN, room, wordCommit, memWrite, push, pop, bufReady, cellSent;
    logic [5:0]  used;
    send_state_t state_q, state_d;

    assign flushN     = memCtl_q[`BIT_INS_RESET_N];
    assign used       = {1'b0, wrPtr_q - rdPtr_q};
    assign room       = used <= `MEM_ROOM_LIMIT;
    assign wordCommit = wrStb && addr == `OFS_INS_DATA0 && flushN;
    // a word outside a flagged cell is dropped, and a new cell needs room
    assign memWrite   = wordCommit && (wrIdx_q != 5'h0 || (memCtl_q[`BIT_WRITE_SOC] && room));
    assign push       = state_q == SEND_BUSY && bufReady;
    assign cellSent   = push && sendIdx_q == `LAST_WORD;

    // the write pointer advances a whole cell at a time, so partial cells are never visible to the sender
    always_comb begin
        wrPtr_d   = wrPtr_q;
        rdPtr_d   = rdPtr_q;
        wrIdx_d   = wrIdx_q;
        sendIdx_d = sendIdx_q;
        asm_d     = asm_q;
        state_d   = state_q;
        if (wrStb && addr == `OFS_INS_DATA3) asm_d[23:16] = wrData;
        if (wrStb && addr == `OFS_INS_DATA2) asm_d[15:8]  = wrData;
        if (wrStb && addr == `OFS_INS_DATA1) asm_d[7:0]   = wrData;
        if (memWrite) begin
            if (memCtl_q[`BIT_WRITE_SOC]) begin
                wrIdx_d = 5'h1;
            end else if (wrIdx_q == `LAST_WORD) begin
                wrIdx_d = 5'h0;
                wrPtr_d = wrPtr_q + `CELL_WORDS;
            end else begin
                wrIdx_d = wrIdx_q + 5'h1;
            end
        end
        case (state_q)
            SEND_IDLE: begin
                if (used != 6'h0 && txFifoEmpty) state_d = SEND_BUSY;
            end
            SEND_BUSY: begin
                if (push) begin
                    rdPtr_d   = rdPtr_q + 5'h1;
                    sendIdx_d = cellSent ? 5'h0 : sendIdx_q + 5'h1;
                    if (cellSent) state_d = SEND_IDLE;
                end
            end
            default: state_d = SEND_IDLE;
        endcase
        if (!flushN) begin
            wrPtr_d   = 5'h0;
            rdPtr_d   = 5'h0;
            wrIdx_d   = 5'h0;
            sendIdx_d = 5'h0;
            state_d   = SEND_IDLE;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_q   <= 5'h0;
            rdPtr_q   <= 5'h0;
            wrIdx_q   <= 5'h0;
            sendIdx_q <= 5'h0;
            asm_q     <= 24'h0;
            state_q   <= SEND_IDLE;
        end else begin
            wrPtr_q   <= wrPtr_d;
            rdPtr_q   <= rdPtr_d;
            wrIdx_q   <= wrIdx_d;
            sendIdx_q <= sendIdx_d;
            asm_q     <= asm_d;
            state_q   <= state_d;
        end
    end
    // storage has no reset; it is only read behind committed pointers
    always_ff @(posedge clk) begin
        if (memWrite) mem[memCtl_q[`BIT_WRITE_SOC] ? wrPtr_q : wrPtr_q + wrIdx_q] <= {asm_q, wrData};
    end

    // ==================================================
    // two-entry output buffer; a stall downstream freezes the sender
    cell_word_t ent0_q, ent0_d, ent1_q, ent1_d, inWord;
    logic       v0_q, v0_d, v1_q, v1_d;
    assign bufReady = !v1_q;
    assign pop      = v0_q && outReady;
    assign inWord   = '{startOfCell: sendIdx_q == 5'h0, endOfCell: sendIdx_q == `LAST_WORD, data: mem[rdPtr_q]};
    always_comb begin
        ent0_d = ent0_q;
        ent1_d = ent1_q;
        v0_d   = v0_q;
        v1_d   = v1_q;
        if (pop) begin
            ent0_d = ent1_q;
            v0_d   = v1_q;
            v1_d   = 1'b0;
        end
        if (push) begin
            if (!v0_d) begin
                ent0_d = inWord;
                v0_d   = 1'b1;
            end else begin
                ent1_d = inWord;
                v1_d   = 1'b1;
            end
        end
        if (!flushN) begin
            v0_d = 1'b0;
            v1_d = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ent0_q <= '0;
            ent1_q <= '0;
            v0_q   <= 1'b0;
            v1_q   <= 1'b0;
        end else begin
            ent0_q <= ent0_d;
            ent1_q <= ent1_d;
            v0_q   <= v0_d;
            v1_q   <= v1_d;
        end
    end
    assign outWord  = ent0_q;
    assign outValid = v0_q;

    // ==================================================
    // control, interrupt and read-back registers
    logic intN_q, intN_d;
    always_comb begin
        memCtl_d  = memCtl_q;
        intEn_d   = intEn_q;
        intStat_d = intStat_q;
        rdData_d  = rdData_q;
        if (wrStb && addr == `OFS_MEM_CONTROL) memCtl_d = {3'h0, wrData[4:2], 1'b0, wrData[0]};
        if (wrStb && addr == `OFS_INT_ENABLE) intEn_d = {2'h0, wrData[5:0]};
        if (memWrite) memCtl_d[`BIT_WRITE_SOC] = 1'b0;               // flag consumed by this word
        if (rdStb) begin
            if (addr == `OFS_MEM_CONTROL) begin
                rdData_d = memCtl_q | {6'h0, room, 1'b0};
            end else if (addr == `OFS_INT_ENABLE) begin
                rdData_d = intEn_q;
            end else if (addr == `OFS_INT_STATUS) begin
                rdData_d  = intStat_q;
                intStat_d = 8'h0;
            end else if (selCnt) begin
                // the MSB comes live and is snapshotted; later bytes come from that snapshot
                case (cntByte)
                    2'h0:    rdData_d = cnt_q[cntFilter][31:24];
                    2'h1:    rdData_d = snap_q[cntFilter][23:16];
                    2'h2:    rdData_d = snap_q[cntFilter][15:8];
                    default: rdData_d = snap_q[cntFilter][7:0];
                endcase
            end else begin
                rdData_d = 8'h00;
            end
        end
        if (cellSent && intEn_q[`BIT_INS_INT]) intStat_d[`BIT_INS_INT] = 1'b1;
        intN_d = !(|(intStat_d & intEn_q));
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memCtl_q  <= `RST_MEM_CONTROL;
            intEn_q   <= `RST_INT_ENABLE;
            intStat_q <= 8'h00;
            rdData_q  <= 8'h00;
            intN_q    <= 1'b1;
        end else begin
            memCtl_q  <= memCtl_d;
            intEn_q   <= intEn_d;
            intStat_q <= intStat_d;
            rdData_q  <= rdData_d;
            intN_q    <= intN_d;
        end
    end
    assign rdData = rdData_q;
    assign intN   = intN_q;

    // ==================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_cnt_no_wrap:  assert property (
        cnt_q[0] == `CNT_SATURATE && !g_filter[0].rdMsb |=> cnt_q[0] == `CNT_SATURATE)
        else $error("counter left saturation");
    a_cnt_clear:    assert property (
        g_filter[1].rdMsb && !filterHit[1] |=> cnt_q[1] == 32'h0)
        else $error("counter not cleared by read");
    a_cnt_incr:     assert property (
        filterHit[2] && !g_filter[2].rdMsb && cnt_q[2] < 32'h10 |=> cnt_q[2] == $past(cnt_q[2]) + 32'h1)
        else $error("counter missed a cell");
    a_snap_hold:    assert property (
        g_filter[3].rdMsb |=> snap_q[3] == $past(cnt_q[3]))
        else $error("snapshot not taken");
    a_send_start:   assert property (
        $rose(state_q == SEND_BUSY) |-> $past(txFifoEmpty))
        else $error("cell started while transmit FIFO busy");
    a_flush_empty:  assert property (
        !flushN |=> used == 6'h0 && !v0_q && state_q == SEND_IDLE)
        else $error("flush left data");
    a_room_flag:    assert property (
        rdStb && addr == `OFS_MEM_CONTROL |=> rdData_q[`BIT_ROOM] == $past(room))
        else $error("room bit wrong");
    a_int_event:    assert property (
        cellSent && intEn_q[`BIT_INS_INT] |=> intStat_q[`BIT_INS_INT] && !intN_q)
        else $error("insertion interrupt missing");
    a_whole_cells:  assert property (
        used % 6'h0E == 6'h0 || state_q == SEND_BUSY)
        else $error("partial cell visible");
    a_sop_first:    assert property (
        outValid && outWord.startOfCell |-> !outWord.endOfCell)
        else $error("start and end of cell together");
    c_cell_sent:    cover property (cellSent);
    c_stall:        cover property (v1_q && !outReady);
    c_saturate:     cover property (cnt_q[0] == `CNT_SATURATE);
    c_flush:        cover property ($rose(flushN));
endmodule : tx_cell_insert

// file: tb/host_model.sv
`timescale 1ns/100ps
`include "tx_cell_insert_regs.svh"
module host_model (
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic      [7:0] wrData,
    output logic            wrStb,
    output logic            rdStb,
    input  wire logic [7:0] rdData
);
    // ==================================
    // idle bus at time zero
    initial begin
        addr = 8'h00;
        wrData = 8'h00;
        wrStb = 1'b0;
        rdStb = 1'b0;
    end
    // one-cycle write strobe, launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wrData = d;
        wrStb = 1'b1;
        @(negedge clk);
        wrStb = 1'b0;
        wrData = ~d; // a released bus must not look like the last byte
    endtask : wr
    // data is valid the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rdStb = 1'b1;
        @(negedge clk);
        rdStb = 1'b0;
        d = rdData;
    endtask : rd
    // counter bytes strictly MSB first
    task automatic rd_count(input int f, output logic [31:0] v);
        for (int j = 0; j < 4; j++) begin
            rd(8'h4C + 8'(16 * f + j), v[31 - 8 * j -: 8]);
        end
    endtask : rd_count
    // one 56-byte cell: room check, SoC flag, then 14 words
    task automatic put_cell(input logic [7:0] first, output logic [7:0] room);
        rd(`OFS_MEM_CONTROL, room);
        wr(`OFS_MEM_CONTROL, 8'h15);
        for (int k = 0; k < 56; k++) begin
            wr(`OFS_INS_DATA3 + 8'(k % 4), first + 8'(k));
        end
    endtask : put_cell
endmodule : host_model

// file: tb/tx_cell_insert_and_filter_count_test.sv
`timescale 1ns/100ps
module tx_cell_insert_and_filter_count_test
    import tx_cell_insert_pkg::*;
;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] addr, wrData, rdData, b;
    logic       wrStb, rdStb, outValid, intN;
    logic [3:0] filterHit = 4'h0;
    logic       txFifoEmpty = 1'b0;
    logic       outReady = 1'b0;
    logic [31:0] v;
    cell_word_t outWord, e;
    cell_word_t got[$];
    int         n_fail = 0;
    int         cmp_count = 0;
    int         ph = 0;

    always #5 clk = ~clk;

    tx_cell_insert i_dut (.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .filterHit(filterHit), .txFifoEmpty(txFifoEmpty),
        .outWord(outWord), .outValid(outValid), .outReady(outReady), .intN(intN));
    host_model i_host (.clk(clk), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData(rdData));

    // ==================================
    // receiver: stalls one cycle in three, so the buffer fills
    always @(negedge clk) begin
        ph <= ph + 1;
        outReady <= (ph % 3 != 0);
    end
    always @(posedge clk) begin
        if (outValid === 1'b1 && outReady === 1'b1) got.push_back(outWord);
    end

    task automatic chk(input logic [33:0] g, input logic [33:0] x, input string m);
        cmp_count++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // ==================================
    // reset values, unmapped place, idle interrupt
    task automatic t_reset;
        i_host.rd(8'h13, b);
        chk(b, 8'h16, "memctl");
        i_host.rd(8'h0F, b);
        chk(b, 8'h10, "intena");
        i_host.rd(8'h30, b);
        chk(b, 8'h00, "unmapped");
        i_host.rd(8'h7D, b);
        chk(b, 8'h00, "count byte");
        chk(intN, 1'b1, "intN idle");
        $display("test reset done");
    endtask : t_reset

    // counts per filter, snapshot kept while a hit lands mid-read
    task automatic t_count;
        for (int f = 0; f < 4; f++) begin
            repeat (f + 1) begin
                @(negedge clk) filterHit = 4'h1 << f;
                @(negedge clk) filterHit = 4'h0;
            end
            for (int j = 0; j < 4; j++) begin
                i_host.rd(8'h4C + 8'(16 * f + j), v[31 - 8 * j -: 8]);
                if (j == 0) begin
                    @(negedge clk) filterHit = 4'h1 << f;
                    @(negedge clk) filterHit = 4'h0;
                end
            end
            chk(v, 32'(f + 1), "snapshot");
            i_host.rd_count(f, v);
            chk(v, 32'h00000001, "after clear");
        end
        $display("test count done");
    endtask : t_count

    // two cells held back, room runs out, then sent in order
    task automatic t_cell;
        i_host.wr(8'h13, 8'h10);
        i_host.wr(8'h13, 8'h14);
        i_host.put_cell(8'h20, b);
        chk(b[1], 1'b1, "room first");
        i_host.put_cell(8'h60, b);
        chk(b[1], 1'b1, "room second");
        i_host.rd(8'h13, b);
        chk(b[1], 1'b0, "room full");
        repeat (20) @(negedge clk);
        chk(outValid, 1'b0, "held back");
        txFifoEmpty = 1'b1;
        for (int i = 0; i < 2000 && got.size() < 28; i++) @(posedge clk);
        chk(got.size(), 28, "word count");
        for (int k = 0; k < got.size(); k++) begin
            b = (k < 14 ? 8'h20 : 8'h60) + 8'(4 * (k % 14));
            e = '{k % 14 == 0, k % 14 == 13, {b, b + 8'h01, b + 8'h02, b + 8'h03}};
            chk(got[k], e, "word");
        end
        repeat (4) @(negedge clk);
        chk(intN, 1'b0, "intN set");
        i_host.rd(8'h0B, b);
        chk(b, 8'h10, "status");
        repeat (3) @(negedge clk);
        chk(intN, 1'b1, "intN clear");
        $display("test cell done");
    endtask : t_cell

    // a flush drops a loaded cell; a cell loaded after release still goes out whole
    task automatic t_flush;
        txFifoEmpty = 1'b0;
        i_host.put_cell(8'hA0, b);
        chk(b[1], 1'b1, "room before flush");
        i_host.wr(8'h13, 8'h10);
        i_host.wr(8'h13, 8'h14);
        i_host.rd(8'h13, b);
        chk(b, 8'h16, "memctl after flush");
        txFifoEmpty = 1'b1;
        repeat (40) @(negedge clk);
        chk(outValid, 1'b0, "flushed cell held");
        chk(got.size(), 28, "flushed cell dropped");
        i_host.put_cell(8'hC0, b);
        for (int i = 0; i < 2000 && got.size() < 42; i++) @(posedge clk);
        chk(got.size(), 42, "cell after flush");
        e = '{1'b1, 1'b0, 32'hC0C1C2C3};
        chk(got[28], e, "first word after flush");
        $display("test flush done");
    endtask : t_flush

    // ==================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        t_reset();
        t_count();
        t_cell();
        t_flush();
        complete_run();
    end
    initial begin
        #300us;
        n_fail++;
        complete_run();
    end
endmodule : tx_cell_insert_and_filter_count_test
